// [verilog/reset_seq_pkg.sv]
// Constants, offsets and types of the reset sequencer
package reset_seq_pkg;
    localparam int CLK_PERIOD_NS = 100;
    localparam int TCL_NS = CLK_PERIOD_NS / 2;
    localparam int SEQ_TCL = 1024;
    localparam int FLASH_TCL = 32;
    localparam int SAMPLE_TCL = 8;
    localparam int LOW_MIN_TCL = 4;
    localparam logic [9:0] SEQ_CYC =
        10'(SEQ_TCL * TCL_NS / CLK_PERIOD_NS);
    localparam logic [9:0] FLASH_CYC =
        10'(FLASH_TCL * TCL_NS / CLK_PERIOD_NS);
    localparam logic [9:0] SAMPLE_CYC =
        10'(SAMPLE_TCL * TCL_NS / CLK_PERIOD_NS);
    localparam logic [2:0] LOW_MIN_CYC =
        3'((LOW_MIN_TCL * TCL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // Register byte offsets
    localparam logic [7:0] ADDR_SYSCFG = 8'h00;
    localparam logic [7:0] ADDR_CMD = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_CFGLAT = 8'h0C;
    // Field positions
    localparam int BIT_BIDIR = 3;
    localparam int BIT_PDPU = 5;
    localparam int CMD_SWRST = 0;
    localparam int CMD_END_OF_INIT_INSTR = 1;
    localparam int FL_LHWR = 0;
    localparam int FL_SHWR = 1;
    localparam int FL_SWR = 2;
    localparam int FL_WDTR = 3;
    localparam int FL_ASYNC = 4;
    localparam int STAT_END_OF_INIT_INSTR = 8;
    localparam int STAT_INRST = 9;
    localparam logic [4:0] FLAGS_RST = 5'h00;
    localparam logic [15:0] CFG_RST = 16'h0000;
    // Synchroniser lanes
    localparam int SY_FILT = 0;
    localparam int SY_PD = 1;
    localparam int SY_RDY = 2;
    localparam int SY_PIN = 3;
    localparam int SY_EA = 4;
    localparam int SY_PORT = 5;
    localparam int SY_W = 21;
    typedef enum logic [2:0] {
        ST_RUN, ST_BUSWAIT, ST_SEQ, ST_SAMPLE, ST_WATCH, ST_LONG
    } state_t;
    typedef enum logic [1:0] {K_HW, K_SW, K_WDT} kind_t;
endpackage

// [verilog/reset_sequencer.sv]
// Reset sequencer with watchdog and bidirectional reset pin
//
// Local design decisions: the APB register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module reset_sequencer
    import reset_seq_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic reset_in_pin_i,
    output logic reset_in_pin_o,
    output logic reset_in_pin_oe,
    input wire logic filtered_reset_in,
    input wire logic power_down_detect_pin,
    output logic pd_pulldown_en,
    output logic pd_pullup_en,
    output logic reset_out_pin,
    output logic core_reset_n,
    input wire logic external_access_select,
    input wire logic [15:0] config_port,
    output logic [15:0] config_latched,
    input wire logic wdog_overflow,
    input wire logic bus_cycle_active,
    input wire logic bus_ready_used,
    input wire logic bus_wait_done,
    input wire logic ready_pin,
    output logic bus_abort
);
    localparam int A_SEQ_LO = 511;
    localparam int A_SEQ_EXT = 17;

    logic [SY_W-1:0] sync1_ff, sync2_ff;
    state_t state_ff, nxt_state;
    kind_t kind_ff, nxt_kind;
    logic [9:0] cnt_ff, nxt_cnt;
    logic [2:0] low_ff, nxt_low;
    logic [4:0] flags_ff, nxt_flags;
    logic [15:0] cfg_ff, nxt_cfg;
    logic bidir_en_ff, nxt_bidir_en;
    logic pdpu_cfg_ff, nxt_pdpu_cfg;
    logic pullup_ff, nxt_pullup;
    logic drive_ff, nxt_drive;
    logic reset_out_pin_ff, nxt_reset_out_pin;
    logic end_of_init_instr_ff, nxt_end_of_init_instr;
    logic core_ff, nxt_core;
    logic abort_ff, nxt_abort;
    logic pulldown_ff, nxt_pulldown;
    logic pready_ff, nxt_pready;
    logic pslverr_ff, nxt_pslverr;
    logic [31:0] prdata_ff, nxt_prdata;
    logic filt_low, pd_low, wr_en, sw_req;
    logic start, start_async;
    kind_t start_kind;
    logic [9:0] seq_last;

    // Address decode for the error answer; the read mux compares paddr itself
    function automatic logic mapped(input logic [7:0] a);
        if (a == ADDR_SYSCFG) begin
            mapped = 1'b1;
        end else if (a == ADDR_CMD) begin
            mapped = 1'b1;
        end else if (a == ADDR_STATUS) begin
            mapped = 1'b1;
        end else if (a == ADDR_CFGLAT) begin
            mapped = 1'b1;
        end else begin
            mapped = 1'b0;
        end
    endfunction

    // Latch the port for the kind of reset that just ended
    function automatic logic [15:0] latch_cfg(input kind_t k,
        input logic [15:0] old, input logic [15:0] port);
        logic [15:0] v;
        v = port;
        if (k != K_HW) begin
            v = old;
            v[12:8] = port[12:8];
            v[7:2] = 6'h3F;
        end
        latch_cfg = v;
    endfunction

    // Two-stage synchronisers for all pins
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_ff <= 21'h1FFFFF;
            sync2_ff <= 21'h1FFFFF;
        end else begin
            sync1_ff <= {config_port, external_access_select,
                reset_in_pin_i, ready_pin, power_down_detect_pin,
                filtered_reset_in};
            sync2_ff <= sync1_ff;
        end
    end

    assign filt_low = !sync2_ff[SY_FILT];
    assign pd_low = !sync2_ff[SY_PD];
    assign wr_en = psel && penable && pwrite && pready_ff;
    assign sw_req = wr_en && (paddr == ADDR_CMD) && pwdata[CMD_SWRST];
    assign seq_last = sync2_ff[SY_EA] ? SEQ_CYC + FLASH_CYC - 10'h001
                                      : SEQ_CYC - 10'h001;

    // APB slave: one wait state, error on unmapped address
    always_comb begin
        nxt_pready = psel && penable && !pready_ff;
        nxt_pslverr = nxt_pready && !mapped(paddr);
        nxt_prdata = 32'h00000000;
        if (nxt_pready && !pwrite) begin
            if (paddr == ADDR_SYSCFG) begin
                nxt_prdata[BIT_BIDIR] = bidir_en_ff;
                nxt_prdata[BIT_PDPU] = pdpu_cfg_ff;
            end else if (paddr == ADDR_STATUS) begin
                nxt_prdata[4:0] = flags_ff;
                nxt_prdata[STAT_END_OF_INIT_INSTR] = end_of_init_instr_ff;
                nxt_prdata[STAT_INRST] = !core_ff;
            end else if (paddr == ADDR_CFGLAT) begin
                nxt_prdata[15:0] = cfg_ff;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h00000000;
        end else begin
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            prdata_ff <= nxt_prdata;
        end
    end

    // Reset sequence control and configuration bits
    always_comb begin
        nxt_state = state_ff;
        nxt_kind = kind_ff;
        nxt_cnt = cnt_ff;
        nxt_low = 3'h0;
        nxt_flags = flags_ff;
        nxt_cfg = cfg_ff;
        nxt_bidir_en = bidir_en_ff;
        nxt_pdpu_cfg = pdpu_cfg_ff;
        nxt_pullup = pullup_ff;
        nxt_drive = drive_ff;
        nxt_reset_out_pin = reset_out_pin_ff;
        nxt_end_of_init_instr = end_of_init_instr_ff;
        nxt_core = core_ff;
        nxt_abort = 1'b0;
        start = 1'b0;
        start_async = 1'b0;
        start_kind = K_HW;
        // Saturating low count; a wrap would hide a long low input
        if (filt_low) begin
            nxt_low = (low_ff == 3'h7) ? low_ff : low_ff + 3'h1;
        end
        if (wr_en && paddr == ADDR_SYSCFG) begin
            if (!end_of_init_instr_ff) begin
                nxt_bidir_en = pwdata[BIT_BIDIR];
            end
            nxt_pdpu_cfg = pwdata[BIT_PDPU];
        end
        if (wr_en && paddr == ADDR_STATUS) begin
            nxt_flags = flags_ff & ~pwdata[4:0];
        end
        if (wr_en && paddr == ADDR_CMD && pwdata[CMD_END_OF_INIT_INSTR]
            && core_ff && state_ff == ST_RUN) begin
            nxt_end_of_init_instr = 1'b1;
            nxt_reset_out_pin = 1'b1;
        end
        case (state_ff)
            ST_RUN: begin
                if (filt_low && pd_low) begin
                    start = 1'b1;
                    start_async = 1'b1;
                end else if (filt_low && low_ff >= LOW_MIN_CYC - 3'h1) begin
                    start = 1'b1;
                end else if (sw_req) begin
                    start = 1'b1;
                    start_kind = K_SW;
                end else if (wdog_overflow) begin
                    if (bus_cycle_active) begin
                        nxt_state = ST_BUSWAIT;
                    end else begin
                        start = 1'b1;
                        start_kind = K_WDT;
                    end
                end
            end
            ST_BUSWAIT: begin
                if (!bus_cycle_active) begin
                    start = 1'b1;
                    start_kind = K_WDT;
                end else if (bus_wait_done && bus_ready_used
                             && sync2_ff[SY_RDY]) begin
                    nxt_abort = 1'b1;
                    start = 1'b1;
                    start_kind = K_WDT;
                end
            end
            ST_SEQ: begin
                nxt_cnt = cnt_ff + 10'h001;
                if (kind_ff != K_HW && pd_low) begin
                    nxt_drive = 1'b0;
                end
                if (cnt_ff >= seq_last) begin
                    nxt_drive = 1'b0;
                    nxt_pullup = pdpu_cfg_ff;
                    nxt_cnt = 10'h000;
                    if (kind_ff == K_HW) begin
                        nxt_state = ST_SAMPLE;
                    end else begin
                        nxt_cfg = latch_cfg(kind_ff, cfg_ff,
                            sync2_ff[20:5]);
                        nxt_core = 1'b1;
                        nxt_state = ST_WATCH;
                    end
                end
            end
            ST_SAMPLE: begin
                nxt_cnt = cnt_ff + 10'h001;
                if (cnt_ff == SAMPLE_CYC - 10'h001) begin
                    if (filt_low) begin
                        nxt_flags[FL_LHWR] = 1'b1;
                        nxt_state = ST_LONG;
                    end else begin
                        nxt_cfg = latch_cfg(K_HW, cfg_ff, sync2_ff[20:5]);
                        nxt_core = 1'b1;
                        nxt_state = ST_RUN;
                    end
                end
            end
            ST_LONG: begin
                if (!filt_low) begin
                    nxt_cfg = latch_cfg(K_HW, cfg_ff, sync2_ff[20:5]);
                    nxt_core = 1'b1;
                    nxt_state = ST_RUN;
                end
            end
            ST_WATCH: begin
                nxt_cnt = cnt_ff + 10'h001;
                if (cnt_ff == SAMPLE_CYC - 10'h001) begin
                    nxt_state = ST_RUN;
                    if (filt_low && low_ff >= LOW_MIN_CYC - 3'h1) begin
                        start = 1'b1;
                    end
                end
            end
            default: begin
                nxt_state = ST_RUN;
            end
        endcase
        // Common entry into the internal sequence
        if (start) begin
            nxt_state = ST_SEQ;
            nxt_kind = start_kind;
            nxt_cnt = 10'h000;
            nxt_core = 1'b0;
            nxt_reset_out_pin = 1'b0;
            nxt_end_of_init_instr = 1'b0;
            nxt_bidir_en = 1'b0;
            nxt_pullup = 1'b0;
            // Watchdog and software drive the pin only while detect is high; hardware ignores detect
            nxt_drive = bidir_en_ff && (start_kind == K_HW || !pd_low);
            if (start_kind == K_HW) begin
                nxt_flags = 5'h00;
                nxt_flags[FL_SHWR] = 1'b1;
                nxt_flags[FL_LHWR] = start_async;
                nxt_flags[FL_ASYNC] = start_async;
            end else if (start_kind == K_SW) begin
                nxt_flags = 5'h00;
                nxt_flags[FL_SWR] = 1'b1;
            end else begin
                nxt_flags = 5'h00;
                nxt_flags[FL_WDTR] = 1'b1;
            end
        end
        nxt_pulldown = !sync2_ff[SY_PIN] || drive_ff;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= ST_RUN;
            kind_ff <= K_HW;
            cnt_ff <= 10'h000;
            low_ff <= 3'h0;
            flags_ff <= FLAGS_RST;
            cfg_ff <= CFG_RST;
            bidir_en_ff <= 1'b0;
            pdpu_cfg_ff <= 1'b0;
            pullup_ff <= 1'b0;
            drive_ff <= 1'b0;
            reset_out_pin_ff <= 1'b0;
            end_of_init_instr_ff <= 1'b0;
            core_ff <= 1'b1;
            abort_ff <= 1'b0;
            pulldown_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            kind_ff <= nxt_kind;
            cnt_ff <= nxt_cnt;
            low_ff <= nxt_low;
            flags_ff <= nxt_flags;
            cfg_ff <= nxt_cfg;
            bidir_en_ff <= nxt_bidir_en;
            pdpu_cfg_ff <= nxt_pdpu_cfg;
            pullup_ff <= nxt_pullup;
            drive_ff <= nxt_drive;
            reset_out_pin_ff <= nxt_reset_out_pin;
            end_of_init_instr_ff <= nxt_end_of_init_instr;
            core_ff <= nxt_core;
            abort_ff <= nxt_abort;
            pulldown_ff <= nxt_pulldown;
        end
    end

    // Output pins straight from flops; pin drives only low
    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign reset_in_pin_o = 1'b0;
    assign reset_in_pin_oe = drive_ff;
    assign pd_pulldown_en = pulldown_ff;
    assign pd_pullup_en = pullup_ff;
    assign reset_out_pin = reset_out_pin_ff;
    assign core_reset_n = core_ff;
    assign config_latched = cfg_ff;
    assign bus_abort = abort_ff;

    // Checks on sequence behaviour
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_reset_out_pin_at_start: assert property (
        $fell(core_ff) |-> !reset_out_pin_ff && !end_of_init_instr_ff)
        else $error("reset output not low at sequence start");
    a_bidir_cleared: assert property (
        $rose(state_ff == ST_SEQ) |-> !bidir_en_ff)
        else $error("bidirectional enable not cleared");
    a_pd_release: assert property (
        (state_ff == ST_SEQ && kind_ff != K_HW && pd_low)
        |=> !drive_ff)
        else $error("pin still driven with detect low");
    a_wdog_drive_pd: assert property (
        ($rose(state_ff == ST_SEQ) && kind_ff == K_WDT && drive_ff)
        |-> !$past(pd_low))
        else $error("watchdog drove pin with detect low");
    a_sample_eight: assert property (
        $rose(state_ff == ST_SAMPLE) |->
        (state_ff == ST_SAMPLE)[*4] ##1 (state_ff != ST_SAMPLE))
        else $error("short reset sample not at eight half clocks");
    a_cfg_forced: assert property (
        $rose(state_ff == ST_WATCH) |-> cfg_ff[7:2] == 6'h3F)
        else $error("config bits 7..2 not forced high");
    a_end_of_init_instr_lock: assert property (
        end_of_init_instr_ff |=> !$rose(bidir_en_ff))
        else $error("bidirectional enable set after end of init");
    a_seq_length: assert property (
        $rose(state_ff == ST_SEQ) |->
        ##[A_SEQ_LO:A_SEQ_LO] (state_ff == ST_SEQ)
        ##[1:A_SEQ_EXT] (state_ff != ST_SEQ))
        else $error("internal sequence length wrong");
    a_pulldown_pin: assert property (
        !sync2_ff[SY_PIN] |=> pd_pulldown_en)
        else $error("detect pull-down off while pin low");
    a_degen_hw: assert property (
        (state_ff == ST_WATCH && cnt_ff == SAMPLE_CYC - 10'h001
         && filt_low && low_ff >= 3'h1)
        |=> state_ff == ST_SEQ && kind_ff == K_HW && !flags_ff[FL_SWR])
        else $error("degeneration into hardware reset missed");
endmodule
`default_nettype wire

// [test/reset_circuit_model.sv]
// Model of the board reset line, its input filter and detect pin
`timescale 1ns/10ps
`default_nettype none
module reset_circuit_model (
    input wire logic core_clk,
    input wire logic pin_o,
    input wire logic pin_oe,
    input wire logic ext_low,
    input wire logic [3:0] filt_dly,
    input wire logic pd_level,
    output logic pin_level,
    output logic filt_out,
    output logic pd_pin
);
    logic [3:0] hold_cnt = 4'h0;
    // Wired reset line with pull-up: any party may only pull it low
    assign pin_level = !((pin_oe && !pin_o) || ext_low);
    // Filter output lags the pin release by filt_dly cycles
    always @(posedge core_clk) begin
        if (!pin_level) begin
            hold_cnt <= filt_dly;
        end else if (hold_cnt != 4'h0) begin
            hold_cnt <= hold_cnt - 4'h1;
        end
    end
    assign filt_out = pin_level && (hold_cnt == 4'h0);
    // Detect pin follows the external capacitor level
    assign pd_pin = pd_level;
endmodule
`default_nettype wire

// [test/watchdog_bidir_reset_seq_bench.sv]
// Self-checking bench for the reset sequencer
`timescale 1ns/10ps
`default_nettype none
module watchdog_bidir_reset_seq_bench;
    import reset_seq_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, pin_o, pin_oe, pin_lvl, filt, pd_pin;
    logic pd_dn, pd_up, rst_out, core_n, abort;
    logic [15:0] cfg_lat;
    logic ea = 1'b0;
    logic [15:0] port = 16'h0;
    logic wdog = 1'b0;
    logic bus_act = 1'b0;
    logic rdy_used = 1'b0;
    logic wait_done = 1'b0;
    logic rdy = 1'b1;
    logic ext_low = 1'b0;
    logic pd_lvl = 1'b1;
    logic [3:0] dly = 4'h0;
    logic [15:0] cfg_exp = 16'h0;
    logic [32:0] exp_q[$], msk_q[$], e, m;
    integer seed = 32'h34d9e63c;
    int fails = 0;
    int compares = 0;
    int n = 0;
    reset_sequencer u_reset_sequencer (.core_clk(core_clk), .rst_n(rst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .reset_in_pin_i(pin_lvl), .reset_in_pin_o(pin_o),
        .reset_in_pin_oe(pin_oe), .filtered_reset_in(filt),
        .power_down_detect_pin(pd_pin), .pd_pulldown_en(pd_dn),
        .pd_pullup_en(pd_up), .reset_out_pin(rst_out),
        .core_reset_n(core_n), .external_access_select(ea),
        .config_port(port), .config_latched(cfg_lat), .wdog_overflow(wdog),
        .bus_cycle_active(bus_act), .bus_ready_used(rdy_used),
        .bus_wait_done(wait_done), .ready_pin(rdy), .bus_abort(abort));
    reset_circuit_model u_reset_circuit_model (.core_clk(core_clk),
        .pin_o(pin_o), .pin_oe(pin_oe), .ext_low(ext_low), .filt_dly(dly),
        .pd_level(pd_lvl), .pin_level(pin_lvl), .filt_out(filt),
        .pd_pin(pd_pin));
    // Clock of 100 ns period
    always #50 core_clk = ~core_clk;
    // Verdict and end of run
    task automatic results();
        $display("Compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string s, input logic [31:0] g,
        input logic [31:0] x);
        compares++;
        if (g !== x) begin
            fails++;
            $display("Error %s expected %h seen %h", s, x, g);
        end
    endtask
    task automatic chkb(input string s, input logic g, input logic x);
        chk(s, {31'h0, g}, {31'h0, x});
    endtask
    // APB transfer; expected answer noted for the monitor
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d, input logic [32:0] x, input logic [32:0] k);
        exp_q.push_back(x);
        msk_q.push_back(k);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        // Only the watchdog process ends a wait that never answers
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0, {1'b1, 32'h0});
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x,
        input logic [31:0] k);
        apb(1'b0, a, 32'h0, {1'b0, x}, {1'b1, k});
    endtask
    // Wait for the core reset to reach a level, counting cycles
    task automatic wcore(input logic v, input int lim);
        n = 0;
        while (core_n !== v && n < lim) begin
            @(posedge core_clk);
            n++;
        end
        if (n >= lim) begin
            fails++;
            $display("Error core_reset_n expected %b seen %b", v, core_n);
        end
    endtask
    task automatic wd();
        @(posedge core_clk);
        wdog <= 1'b1;
        @(posedge core_clk);
        wdog <= 1'b0;
    endtask
    task automatic pulse();
        @(posedge core_clk);
        ext_low <= 1'b1;
        repeat (6) @(posedge core_clk);
        ext_low <= 1'b0;
    endtask
    task automatic done(input string s);
        repeat (8) @(posedge core_clk);
        $display("Test %s finished", s);
    endtask
    // Monitor: compares each APB answer with the oldest note
    always @(posedge core_clk) begin
        if (psel && penable && pready === 1'b1) begin
            if (exp_q.size() == 0) begin
                fails++;
                $display("Error apb expected none seen %h", prdata);
            end else begin
                e = exp_q.pop_front();
                m = msk_q.pop_front();
                compares++;
                if (((({pslverr, prdata}) ^ e) & m) !== 33'h0) begin
                    fails++;
                    $display("Error apb %h expected %h seen %h", paddr, e,
                        {pslverr, prdata});
                end
            end
        end
    end
    // Watchdog against hangs
    initial begin
        repeat (30000) @(posedge core_clk);
        fails++;
        $display("Error run expected end seen timeout");
        results();
    end
    // Test sequence
    initial begin
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        chkb("reset_out", rst_out, 1'b0);
        chkb("core_reset_n", core_n, 1'b1);
        rd(ADDR_STATUS, 32'h0, 32'h1F);
        apb(1'b0, 8'h10, 32'h0, {1'b1, 32'h0}, {1'b1, 32'hFFFFFFFF});
        apb(1'b1, 8'h14, 32'h1, {1'b1, 32'h0}, {1'b1, 32'h0});
        done("reset");
        port <= 16'($random(seed));
        wr(ADDR_SYSCFG, 32'h28);
        rd(ADDR_SYSCFG, 32'h28, 32'h28);
        wr(ADDR_CMD, 32'h1);
        wcore(1'b0, 10);
        chkb("oe", pin_oe, 1'b1);
        chkb("reset_out", rst_out, 1'b0);
        chkb("pin", pin_lvl, 1'b0);
        wcore(1'b1, 600);
        chk("sw_len", 32'(n), 32'(SEQ_CYC));
        chkb("oe_end", pin_oe, 1'b0);
        chkb("pin_o", pin_o, 1'b0);
        repeat (8) @(posedge core_clk);
        rd(ADDR_SYSCFG, 32'h0, 32'h08);
        chkb("pullup", pd_up, 1'b1);
        rd(ADDR_STATUS, 32'h4, 32'hF);
        cfg_exp = (cfg_exp & 16'hE003) | (port & 16'h1F00) | 16'h00FC;
        rd(ADDR_CFGLAT, {16'h0, cfg_exp}, 32'hFFFF);
        done("software bidir");
        port <= 16'($random(seed));
        ea <= 1'b1;
        pd_lvl <= 1'b0;
        wr(ADDR_SYSCFG, 32'h08);
        bus_act <= 1'b1;
        wd();
        repeat (10) @(posedge core_clk);
        chkb("core_wait", core_n, 1'b1);
        bus_act <= 1'b0;
        wcore(1'b0, 10);
        chkb("oe_pd_low", pin_oe, 1'b0);
        wcore(1'b1, 700);
        chk("flash_len", 32'(n), 32'(SEQ_CYC + FLASH_CYC));
        ea <= 1'b0;
        pd_lvl <= 1'b1;
        repeat (8) @(posedge core_clk);
        rd(ADDR_STATUS, 32'h08, 32'h18);
        cfg_exp = (cfg_exp & 16'hE003) | (port & 16'h1F00) | 16'h00FC;
        rd(ADDR_CFGLAT, {16'h0, cfg_exp}, 32'hFFFF);
        chk("config_latched", {16'h0, cfg_lat}, {16'h0, cfg_exp});
        done("watchdog wait");
        wr(ADDR_SYSCFG, 32'h08);
        bus_act <= 1'b1;
        rdy_used <= 1'b1;
        wait_done <= 1'b1;
        rdy <= 1'b0;
        wd();
        repeat (6) @(posedge core_clk);
        chkb("no_abort", abort, 1'b0);
        chkb("core_ready_low", core_n, 1'b1);
        rdy <= 1'b1;
        for (int i = 0; i < 20 && abort !== 1'b1; i++) @(posedge core_clk);
        chkb("bus_abort", abort, 1'b1);
        bus_act <= 1'b0;
        rdy_used <= 1'b0;
        wait_done <= 1'b0;
        wcore(1'b0, 10);
        chkb("oe_wdt", pin_oe, 1'b1);
        repeat (100) @(posedge core_clk);
        pd_lvl <= 1'b0;
        repeat (5) @(posedge core_clk);
        chkb("oe_release", pin_oe, 1'b0);
        chkb("core_held", core_n, 1'b0);
        pd_lvl <= 1'b1;
        wcore(1'b1, 600);
        chk("wdt_len", 32'(n + 105), 32'(SEQ_CYC));
        done("watchdog abort");
        port <= 16'($random(seed));
        wr(ADDR_SYSCFG, 32'h08);
        dly <= 4'h8;
        wr(ADDR_CMD, 32'h1);
        wcore(1'b0, 10);
        wcore(1'b1, 600);
        wcore(1'b0, 20);
        dly <= 4'h0;
        wcore(1'b1, 800);
        repeat (8) @(posedge core_clk);
        rd(ADDR_STATUS, 32'h2, 32'hF);
        cfg_exp = port;
        rd(ADDR_CFGLAT, {16'h0, cfg_exp}, 32'hFFFF);
        done("degeneration");
        wr(ADDR_SYSCFG, 32'h08);
        pulse();
        wcore(1'b0, 10);
        chkb("oe_hw", pin_oe, 1'b1);
        wcore(1'b1, 800);
        repeat (8) @(posedge core_clk);
        rd(ADDR_STATUS, 32'h2, 32'h3);
        done("short hardware");
        wr(ADDR_SYSCFG, 32'h08);
        dly <= 4'hC;
        pulse();
        wcore(1'b0, 10);
        wcore(1'b1, 900);
        dly <= 4'h0;
        repeat (8) @(posedge core_clk);
        rd(ADDR_STATUS, 32'h3, 32'h3);
        done("long hardware");
        pd_lvl <= 1'b0;
        @(posedge core_clk);
        ext_low <= 1'b1;
        repeat (8) @(posedge core_clk);
        chkb("pulldown", pd_dn, 1'b1);
        ext_low <= 1'b0;
        pd_lvl <= 1'b1;
        wcore(1'b1, 800);
        repeat (8) @(posedge core_clk);
        rd(ADDR_STATUS, 32'h10, 32'h10);
        done("async hardware");
        wr(ADDR_CMD, 32'h2);
        repeat (2) @(posedge core_clk);
        chkb("reset_out_end_of_init_instr", rst_out, 1'b1);
        wr(ADDR_SYSCFG, 32'h08);
        rd(ADDR_SYSCFG, 32'h0, 32'h08);
        rd(ADDR_STATUS, 32'h100, 32'h100);
        done("end of init");
        results();
    end
endmodule
`default_nettype wire
